//--- logic/cidt_defs.svh
`ifndef CIDT_DEFS_SVH
`define CIDT_DEFS_SVH
// ==========================================================
// Register numbers
`define CIDT_R_PC 4'd0
`define CIDT_R_SP 4'd1
`define CIDT_R_SR 4'd2
`define CIDT_R_CG 4'd3
// ==========================================================
// Flag register bit positions
`define CIDT_F_C 0
`define CIDT_F_Z 1
`define CIDT_F_N 2
`define CIDT_F_GIE 3
`define CIDT_F_V 8
// ==========================================================
// Vectors
`define CIDT_VEC_RST 16'hfffe
`define CIDT_VEC_IRQ 16'hfffc
// ==========================================================
// Cycle counts
`define CIDT_CYC_RR 4'd1
`define CIDT_CYC_IR 4'd2
`define CIDT_CYC_XR 4'd3
`define CIDT_CYC_RX 4'd4
`define CIDT_CYC_IX 4'd5
`define CIDT_CYC_XX 4'd6
`define CIDT_CYC_PCDST 4'd1
`define CIDT_CYC_JUMP 4'd2
`define CIDT_CYC_INTERRUPT_RETURN 4'd5
`define CIDT_CYC_IRQ 4'd6
`define CIDT_CYC_RST 4'd4
`define CIDT_CYC_SH_R 4'd1
`define CIDT_CYC_SH_I 4'd3
`define CIDT_CYC_SH_A 4'd3
`define CIDT_CYC_SH_X 4'd4
`define CIDT_CYC_PU_R 4'd3
`define CIDT_CYC_PU_I 4'd4
`define CIDT_CYC_PU_A 4'd4
`define CIDT_CYC_PU_X 4'd5
`define CIDT_CYC_CA_R 4'd4
`define CIDT_CYC_CA_I 4'd4
`define CIDT_CYC_CA_A 4'd5
`define CIDT_CYC_CA_X 4'd5
// ==========================================================
// Register bus map
`define CIDT_REG_CTRL 8'h00
`define CIDT_REG_PC 8'h04
`define CIDT_REG_FLAGS 8'h08
`define CIDT_CTRL_RESET 1'b1
`endif

//--- logic/cidt_pkg.sv
package cidt_pkg;
  typedef enum logic [3:0] {
    s_rst = 4'b0000, s_fetch = 4'b0001, s_sext = 4'b0010, s_srd = 4'b0011,
    s_dext = 4'b0100, s_drd = 4'b0101, s_wr = 4'b0110, s_push = 4'b0111,
    s_pop1 = 4'b1000, s_pop2 = 4'b1001, s_int1 = 4'b1010, s_int2 = 4'b1011,
    s_int3 = 4'b1100, s_wait = 4'b1101
  } cidt_state_t;
  typedef enum logic [3:0] {
    copy_op = 4'h4, sum_op = 4'h5, sum_with_carry = 4'h6, difference_with_carry = 4'h7,
    difference_op = 4'h8, compare_op = 4'h9, decimal_sum = 4'ha, mask_test_op = 4'hb,
    clear_bits_op = 4'hc, set_bits_op = 4'hd, exclusive_or = 4'he,
    bitwise_conjunction = 4'hf
  } cidt_op_t;
  typedef enum logic [2:0] {
    rotate_right_through_carry = 3'b000, byte_swap = 3'b001, shift_right_arith = 3'b010,
    sign_extend = 3'b011, stack_store = 3'b100, subroutine_jump = 3'b101,
    interrupt_return = 3'b110, op2_unused = 3'b111
  } cidt_op2_t;
endpackage

//--- logic/cidt_core.sv
`timescale 1ns/100ps
`include "cidt_defs.svh"
// Functional notes
// - Autoincrement reads operand, then adds 1/2
// - Pointer increments only after operand fetch
// - Cycle counts use main clock periods
// - Double-operand cycle table by source/destination
// - Program counter register-mode destination costs one more
// - Double-operand length: extension words per mode
// - Single-operand cycle table per mode
// - Jumps: one word, two cycles always
// - Return 5, interrupt 6, resets 4
// - Double-operand instruction field layout
// - Byte select: 0 word, 1 byte
// - Double-operand arithmetic computations
// - Flag effects per double-operand operation
// - Compare and mask test skip writeback
// - Rotate and arithmetic shift behaviour
// - Stack store and subroutine jump push
// - Interrupt return pops flags then counter
// - Subroutine jump accepts all modes
// - Source and destination mode encodings
// - Registers 2 and 3 generate constants
// - Jump offset signed, doubled, no flags
// - Jump conditions on zero, carry, sign
module cidt_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [1:0] mem_be,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic irq,
  output logic irq_ack,
  input wire logic watchdog_reset
);
  import cidt_pkg::*;

  // ==========================================================
  // Helper functions
  function automatic logic msb(input logic [15:0] x, input logic b);
    return b ? x[7] : x[15];
  endfunction

  // 0 register or constant, 1 indirect, 2 autoincrement/immediate, 3 indexed
  function automatic logic [1:0] mode_cls(input logic [15:0] w);
    logic [3:0] s;
    s = (w[15:14] != 2'b00) ? w[11:8] : w[3:0];
    if (s == `CIDT_R_CG || (s == `CIDT_R_SR && w[5]) || w[5:4] == 2'b00) return 2'd0;
    if (w[5:4] == 2'b01) return 2'd3;
    return (w[5:4] == 2'b10) ? 2'd1 : 2'd2;
  endfunction

  function automatic logic [3:0] cost_fn(input logic [15:0] w);
    logic [1:0] m;
    logic [3:0] c;
    m = mode_cls(w);
    c = `CIDT_CYC_RR;
    if (w[15:13] == 3'b001) c = `CIDT_CYC_JUMP;
    else if (w[15:14] != 2'b00) begin
      if (w[7]) c = (m == 2'd0) ? `CIDT_CYC_RX : (m == 2'd3) ? `CIDT_CYC_XX : `CIDT_CYC_IX;
      else begin
        c = (m == 2'd0) ? `CIDT_CYC_RR : (m == 2'd3) ? `CIDT_CYC_XR : `CIDT_CYC_IR;
        if (w[3:0] == `CIDT_R_PC) c = c + `CIDT_CYC_PCDST;
      end
    end else if (w[15:10] == 6'b000100) begin
      unique case (w[9:7])
        3'b100: c = (m == 2'd0) ? `CIDT_CYC_PU_R : (m == 2'd1) ? `CIDT_CYC_PU_I :
                    (m == 2'd2) ? `CIDT_CYC_PU_A : `CIDT_CYC_PU_X;
        3'b101: c = (m == 2'd0) ? `CIDT_CYC_CA_R : (m == 2'd1) ? `CIDT_CYC_CA_I :
                    (m == 2'd2) ? `CIDT_CYC_CA_A : `CIDT_CYC_CA_X;
        3'b110: c = `CIDT_CYC_INTERRUPT_RETURN;
        3'b111: c = `CIDT_CYC_RR;
        default: c = (m == 2'd0) ? `CIDT_CYC_SH_R : (m == 2'd1) ? `CIDT_CYC_SH_I :
                     (m == 2'd2) ? `CIDT_CYC_SH_A : `CIDT_CYC_SH_X;
      endcase
    end
    return c;
  endfunction

  function automatic logic [15:0] cg_val(input logic [3:0] r, input logic [1:0] m);
    if (r == `CIDT_R_SR) return m[0] ? 16'h0008 : 16'h0004;
    unique case (m)
      2'b00: return 16'h0000;
      2'b01: return 16'h0001;
      2'b10: return 16'h0002;
      2'b11: return 16'hffff;
    endcase
  endfunction

  function automatic logic [16:0] dec_add(input logic [15:0] a, input logic [15:0] b,
                                          input logic ci, input logic bw);
    logic [4:0] t;
    logic c;
    logic [15:0] r;
    c = ci;
    r = 16'h0000;
    t = 5'h00;
    for (int k = 0; k < 4; k++) begin
      if (!bw || k < 2) begin
        t = {1'b0, a[4*k +: 4]} + {1'b0, b[4*k +: 4]} + {4'h0, c};
        c = (t > 5'd9);
        if (c) t = t + 5'd6;
        r[4*k +: 4] = t[3:0];
      end
    end
    return {c, r};
  endfunction

  // ==========================================================
  // State and decode
  logic [15:0] rf [16];
  cidt_state_t state, next_state, done_state, after_src;
  logic [15:0] ir, sop, dop, sadr, dadr, iw, rv, src_v, dst_v, rdata_sz, pc_inc, joff;
  logic [15:0] sp_dec, sp_inc, step;
  logic [3:0] cost, cyc, cur_cost, sreg, dreg;
  logic [1:0] as, mcls;
  logic f1, f2, fj, bad, ad, bw, imm, single, is_call, jump_cond, cflag;
  logic run, irq_meta, irq_sync, take_irq, fetching, reg_exec, do_exec;
  cidt_op_t op1;
  cidt_op2_t op2;

  assign iw = (state == s_fetch) ? mem_rdata : ir;
  assign f1 = (iw[15:14] != 2'b00);
  assign f2 = (iw[15:10] == 6'b000100);
  assign fj = (iw[15:13] == 3'b001);
  assign op1 = cidt_op_t'(iw[15:12]);
  assign op2 = cidt_op2_t'(iw[9:7]);
  assign sreg = f1 ? iw[11:8] : iw[3:0];
  assign dreg = iw[3:0];
  assign ad = iw[7];
  assign bw = iw[6];
  assign as = iw[5:4];
  assign mcls = mode_cls(iw);
  assign imm = (sreg == `CIDT_R_PC) && (as == 2'b11);
  assign single = f2 && !iw[9];
  assign is_call = f2 && (op2 == subroutine_jump);
  assign bad = !(f1 || f2 || fj) || (f2 && op2 == op2_unused);
  assign cflag = rf[`CIDT_R_SR][`CIDT_F_C];
  assign take_irq = run && irq_sync && rf[`CIDT_R_SR][`CIDT_F_GIE];
  assign fetching = (state == s_fetch) && run && !take_irq;
  assign pc_inc = rf[`CIDT_R_PC] + 16'd2;
  assign sp_dec = rf[`CIDT_R_SP] - 16'd2;
  assign sp_inc = rf[`CIDT_R_SP] + 16'd2;
  assign step = bw ? 16'd1 : 16'd2;
  assign joff = {{5{iw[9]}}, iw[9:0], 1'b0};
  assign rv = (mcls == 2'd0 && sreg >= `CIDT_R_SR && as != 2'b00) || sreg == `CIDT_R_CG ?
              cg_val(sreg, as) : rf[sreg];
  assign rdata_sz = bw ? {8'h00, mem_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]} : mem_rdata;
  assign src_v = (state == s_sext || state == s_srd) ? rdata_sz :
                 (state == s_fetch) ? rv : sop;
  assign dst_v = (state == s_wr) ? dop : rf[dreg];
  assign cur_cost = (state == s_fetch) ? cost_fn(iw) : cost;
  assign done_state = (cyc >= cur_cost - 4'd1) ? s_fetch : s_wait;
  assign irq_ack = (state == s_int3);

  always_comb begin
    unique case (iw[12:10])
      3'b000: jump_cond = !rf[`CIDT_R_SR][`CIDT_F_Z];
      3'b001: jump_cond = rf[`CIDT_R_SR][`CIDT_F_Z];
      3'b010: jump_cond = !cflag;
      3'b011: jump_cond = cflag;
      3'b100: jump_cond = rf[`CIDT_R_SR][`CIDT_F_N];
      3'b101: jump_cond = !(rf[`CIDT_R_SR][`CIDT_F_N] ^ rf[`CIDT_R_SR][`CIDT_F_V]);
      3'b110: jump_cond = rf[`CIDT_R_SR][`CIDT_F_N] ^ rf[`CIDT_R_SR][`CIDT_F_V];
      3'b111: jump_cond = 1'b1;
    endcase
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    if (f1) after_src = ad ? s_dext : done_state;
    else if (op2 == stack_store || is_call) after_src = s_push;
    else after_src = (mcls == 2'd0) ? done_state : s_wr;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      s_fetch: begin
        if (take_irq) next_state = s_int1;
        else if (run) begin
          if (fj || bad) next_state = done_state;
          else if (f2 && op2 == interrupt_return) next_state = s_pop1;
          else if (mcls == 2'd0) next_state = after_src;
          else if (mcls == 2'd3 || imm) next_state = s_sext;
          else next_state = s_srd;
        end
      end
      s_sext: next_state = imm ? after_src : s_srd;
      s_srd: next_state = after_src;
      s_dext: next_state = s_drd;
      s_drd: next_state = s_wr;
      s_pop1: next_state = s_pop2;
      s_int1: next_state = s_int2;
      s_int2: next_state = s_int3;
      s_rst, s_wr, s_push, s_pop2, s_int3, s_wait: next_state = done_state;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || watchdog_reset) begin
      state <= s_rst;
      cyc <= 4'd0;
      cost <= `CIDT_CYC_RST;
    end else begin
      state <= next_state;
      cyc <= (next_state == s_fetch) ? 4'd0 : cyc + 4'd1;
      if (state == s_fetch) cost <= take_irq ? `CIDT_CYC_IRQ : cost_fn(iw);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq;
      irq_sync <= irq_meta;
    end
  end

  // ==========================================================
  // Operation unit
  logic [15:0] msk, ua, ub, ax, res, res_sz;
  logic [16:0] sum, dsum;
  logic sub, cin, nf, zf, cf, vf, fl_upd, wr_en;

  assign msk = bw ? 16'h00ff : 16'hffff;
  assign ua = src_v & msk;
  assign ub = dst_v & msk;
  assign sub = (op1 == difference_op) || (op1 == difference_with_carry) || (op1 == compare_op);
  assign ax = sub ? (~ua & msk) : ua;
  assign cin = (op1 == difference_op || op1 == compare_op) ? 1'b1 :
               (op1 == sum_with_carry || op1 == difference_with_carry) ? cflag : 1'b0;
  assign sum = {1'b0, ub} + {1'b0, ax} + {16'h0000, cin};
  assign dsum = dec_add(ua, ub, cflag, bw);
  assign nf = msb(res, bw);
  assign zf = ((res & msk) == 16'h0000);
  assign res_sz = bw ? {8'h00, res[7:0]} : res;

  always_comb begin
    res = sum[15:0];
    cf = bw ? sum[8] : sum[16];
    vf = (msb(ax, bw) == msb(ub, bw)) && (msb(sum[15:0], bw) != msb(ax, bw));
    fl_upd = 1'b1;
    wr_en = 1'b1;
    if (f1) begin
      unique case (op1)
        copy_op: begin
          res = ua;
          fl_upd = 1'b0;
        end
        sum_op, sum_with_carry, difference_op, difference_with_carry: ;
        compare_op: wr_en = 1'b0;
        decimal_sum: begin
          res = dsum[15:0];
          cf = dsum[16];
        end
        bitwise_conjunction, mask_test_op: begin
          res = ua & ub;
          vf = 1'b0;
          cf = ((ua & ub) != 16'h0000);
          wr_en = (op1 == bitwise_conjunction);
        end
        clear_bits_op: begin
          res = ~ua & ub & msk;
          fl_upd = 1'b0;
        end
        set_bits_op: begin
          res = ua | ub;
          fl_upd = 1'b0;
        end
        exclusive_or: begin
          res = ua ^ ub;
          vf = msb(ua, bw) && msb(ub, bw);
          cf = ((ua ^ ub) != 16'h0000);
        end
        default: begin
          fl_upd = 1'b0;
          wr_en = 1'b0;
        end
      endcase
    end else begin
      unique case (op2)
        rotate_right_through_carry: begin
          res = bw ? {8'h00, cflag, ua[7:1]} : {cflag, ua[15:1]};
          cf = ua[0];
          vf = 1'b0;
        end
        shift_right_arith: begin
          res = bw ? {8'h00, ua[7], ua[7:1]} : {ua[15], ua[15:1]};
          cf = ua[0];
          vf = 1'b0;
        end
        byte_swap: begin
          res = {src_v[7:0], src_v[15:8]};
          fl_upd = 1'b0;
        end
        sign_extend: begin
          res = {{8{src_v[7]}}, src_v[7:0]};
          vf = 1'b0;
          cf = (src_v[7:0] != 8'h00);
        end
        default: begin
          fl_upd = 1'b0;
          wr_en = 1'b0;
        end
      endcase
    end
  end

  assign reg_exec = (fetching && mcls == 2'd0 && ((f1 && !ad) || single)) ||
                    (((state == s_sext && imm) || state == s_srd) && f1 && !ad);
  assign do_exec = reg_exec || (state == s_wr);

  // ==========================================================
  // Register file and operand latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 16; k++) rf[k] <= 16'h0000;
      ir <= 16'h0000;
      sop <= 16'h0000;
      dop <= 16'h0000;
      sadr <= 16'h0000;
      dadr <= 16'h0000;
    end else if (watchdog_reset) begin
      rf[`CIDT_R_SR] <= 16'h0000;
    end else begin
      unique case (state)
        s_fetch: if (fetching) begin
          ir <= mem_rdata;
          sop <= rv;
          rf[`CIDT_R_PC] <= (fj && jump_cond) ? pc_inc + joff : pc_inc;
        end
        s_sext: begin
          rf[`CIDT_R_PC] <= pc_inc;
          sop <= src_v;
          sadr <= ((sreg == `CIDT_R_SR) ? 16'h0000 : rf[sreg]) + mem_rdata;
        end
        s_srd: begin
          sop <= src_v;
          if (as != 2'b01) sadr <= rf[sreg];
          if (as == 2'b11) rf[sreg] <= rf[sreg] + step;
        end
        s_dext: begin
          rf[`CIDT_R_PC] <= pc_inc;
          dadr <= ((dreg == `CIDT_R_SR) ? 16'h0000 : rf[dreg]) + mem_rdata;
        end
        s_drd: dop <= rdata_sz;
        s_push: begin
          rf[`CIDT_R_SP] <= sp_dec;
          if (is_call) rf[`CIDT_R_PC] <= sop;
        end
        s_pop1: begin
          rf[`CIDT_R_SR] <= mem_rdata;
          rf[`CIDT_R_SP] <= sp_inc;
        end
        s_pop2: begin
          rf[`CIDT_R_PC] <= mem_rdata;
          rf[`CIDT_R_SP] <= sp_inc;
        end
        s_int1: rf[`CIDT_R_SP] <= sp_dec;
        s_int2: begin
          rf[`CIDT_R_SP] <= sp_dec;
          rf[`CIDT_R_SR][`CIDT_F_GIE] <= 1'b0;
        end
        s_int3, s_rst: rf[`CIDT_R_PC] <= mem_rdata;
        s_wr, s_wait: ;
      endcase
      if (do_exec && fl_upd) begin
        rf[`CIDT_R_SR][`CIDT_F_C] <= cf;
        rf[`CIDT_R_SR][`CIDT_F_Z] <= zf;
        rf[`CIDT_R_SR][`CIDT_F_N] <= nf;
        rf[`CIDT_R_SR][`CIDT_F_V] <= vf;
      end
      if (reg_exec && wr_en) rf[dreg] <= res_sz;
    end
  end

  // ==========================================================
  // Memory bus
  always_comb begin
    mem_addr = rf[`CIDT_R_PC];
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_be = 2'b11;
    mem_wdata = bw ? {res[7:0], res[7:0]} : res;
    unique case (state)
      s_fetch: mem_rd = fetching;
      s_sext, s_dext: mem_rd = 1'b1;
      s_srd: begin
        mem_rd = 1'b1;
        mem_addr = (as == 2'b01) ? sadr : rf[sreg];
      end
      s_drd: begin
        mem_rd = 1'b1;
        mem_addr = dadr;
      end
      s_wr: begin
        mem_wr = wr_en;
        mem_addr = f1 ? dadr : sadr;
        if (bw) mem_be = mem_addr[0] ? 2'b10 : 2'b01;
      end
      s_push, s_int1, s_int2: begin
        mem_wr = 1'b1;
        mem_addr = sp_dec;
        if (state == s_int1 || is_call) mem_wdata = rf[`CIDT_R_PC];
        else if (state == s_int2) mem_wdata = rf[`CIDT_R_SR];
        else begin
          mem_wdata = bw ? {sop[7:0], sop[7:0]} : sop;
          if (bw) mem_be = 2'b01;
        end
      end
      s_pop1, s_pop2: begin
        mem_rd = 1'b1;
        mem_addr = rf[`CIDT_R_SP];
      end
      s_int3: begin
        mem_rd = 1'b1;
        mem_addr = `CIDT_VEC_IRQ;
      end
      s_rst: begin
        mem_rd = 1'b1;
        mem_addr = `CIDT_VEC_RST;
      end
      s_wait: ;
    endcase
  end

  // ==========================================================
  // Register bus slave
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_strb0;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      run <= `CIDT_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (aw_full && w_full) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `CIDT_REG_CTRL && w_strb0) run <= w_data[0];
        s_axi_bresp <= (aw_addr == `CIDT_REG_CTRL || aw_addr == `CIDT_REG_PC ||
                        aw_addr == `CIDT_REG_FLAGS) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        `CIDT_REG_CTRL: s_axi_rdata <= {31'h0000_0000, run};
        `CIDT_REG_PC: s_axi_rdata <= {16'h0000, rf[`CIDT_R_PC]};
        `CIDT_REG_FLAGS: s_axi_rdata <= {12'h000, state, rf[`CIDT_R_SR]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cidt_core

//--- verif/cidt_core_asserts.sv
`timescale 1ns/100ps
// ==========================================
// Port checks for the core
module cidt_core_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [1:0] mem_be,
  input wire logic [15:0] mem_wdata,
  input wire logic irq_ack,
  input wire logic watchdog_reset,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_idle2;
    (!mem_rd && !mem_wr) [*2];
  endsequence
  sequence s_vec_done;
    mem_rd && mem_addr == 16'hfffe ##1 !mem_rd;
  endsequence
  property p_ack_vec;
    irq_ack |-> mem_rd && mem_addr == 16'hfffc;
  endproperty
  a_ack_vec: assert property (p_ack_vec)
    else $error("ack without vector read");
  property p_ack_idle;
    irq_ack |=> s_idle2 ##1 mem_rd;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("interrupt entry length wrong");
  property p_ack_push;
    irq_ack |-> $past(mem_wr, 2) && $past(mem_wr);
  endproperty
  a_ack_push: assert property (p_ack_push)
    else $error("no two stack writes before vector");
  property p_rst_seq;
    s_vec_done |=> (!mem_rd && !mem_wr) [*2] ##1 mem_rd;
  endproperty
  a_rst_seq: assert property (p_rst_seq)
    else $error("reset sequence length wrong");
  property p_wdog;
    watchdog_reset |-> ##[1:2] (mem_rd && mem_addr == 16'hfffe);
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not restart");
  property p_byte_dup;
    mem_wr && mem_be != 2'b11 |-> mem_wdata[15:8] == mem_wdata[7:0];
  endproperty
  a_byte_dup: assert property (p_byte_dup)
    else $error("byte write data not duplicated");
  property p_be;
    mem_wr |-> mem_be != 2'b00;
  endproperty
  a_be: assert property (p_be)
    else $error("write with no byte enabled");
  property p_excl;
    !(mem_rd && mem_wr);
  endproperty
  a_excl: assert property (p_excl)
    else $error("read and write together");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
endmodule // cidt_core_asserts

//--- verif/cidt_mem.sv
`timescale 1ns/100ps
// ==========================================
// Shared program and data memory
module cidt_mem (
  input wire logic aclk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [1:0] mem_be,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] last = 16'h0000;
  // Idle bus shows the inverse of the last word
  assign mem_rdata = mem_rd ? mem[mem_addr[15:1]] : ~last;
  always @(posedge aclk) begin
    if (mem_rd)
      last <= mem_rdata;
    if (mem_wr && mem_be[0])
      mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
    if (mem_wr && mem_be[1])
      mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
  end
endmodule // cidt_mem

//--- verif/cidt_core_tb.sv
`timescale 1ns/100ps
// ==========================================
// Bench for the decode and timing core
module cidt_core_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, mem_rd, mem_wr, irq, irq_ack, watchdog_reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_be, r;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int cyc = 0;
  int last_vec, fails, checks_done;
  // No immediate mode on shifts or swaps in this program
  logic [15:0] prog [20] = '{16'h4031, 16'h0400, 16'hd232, 16'h4035, 16'h1234,
    16'h4506, 16'h5506, 16'h4682, 16'h0300, 16'h3c01, 16'h4303, 16'h4537,
    16'h4582, 16'h0302, 16'h4578, 16'h4582, 16'h0304, 16'h4782, 16'h0306, 16'h3fff};
  logic [15:0] fa [11] = '{16'h020a, 16'h020c, 16'h020e, 16'h0212, 16'h0216,
    16'h0218, 16'h021c, 16'h021e, 16'h0222, 16'h0226, 16'h0226};
  int fd [11] = '{2, 1, 1, 4, 2, 2, 4, 2, 4, 4, 2};
  logic [15:0] res [4] = '{16'h2468, 16'h1236, 16'h1237, 16'ha5c3};
  cidt_core i_cidt_core (.*);
  cidt_mem i_cidt_mem (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mem_rd === 1'b1 && mem_addr === 16'hfffe)
      last_vec <= cyc;
    if (cyc == 6000) begin
      fails++;
      end_of_test;
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  task automatic wait_fetch(input logic [15:0] a, output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (!(mem_rd === 1'b1 && mem_addr === a) && n < 300);
    t = cyc;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ah, wh, bh;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready === 1'b1;
      wh = s_axi_wvalid && s_axi_wready === 1'b1;
      bh = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
    end while (!bh && n < 50);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ah, rh;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready === 1'b1;
      rh = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ah)
        s_axi_arvalid <= 1'b0;
    end while (!rh && n < 50);
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_timing;
    int t0, t1;
    wait_fetch(16'h0200, t0);
    chk("reset length", 4, 32'(t0 - last_vec));
    wait_fetch(16'h0206, t0);
    for (int i = 0; i < 11; i++) begin
      wait_fetch(fa[i], t1);
      chk("fetch spacing", 32'(fd[i]), 32'(t1 - t0));
      t0 = t1;
    end
    for (int i = 0; i < 4; i++)
      chk("stored word", 32'(res[i]), 32'(i_cidt_mem.mem[384 + i]));
  endtask
  task automatic t_regs;
    axi_rd(8'h08);
    chk("flags", 32'h0008, {16'h0000, d[15:0]});
    axi_rd(8'h0c);
    chk("unmapped resp", 32'h2, 32'(r));
    chk("unmapped data", 32'h0, d);
    axi_wr(8'h00, 32'h0);
    repeat (10) @(posedge aclk);
    #1;
    chk("halted", 32'h0, 32'(mem_rd));
    axi_wr(8'h00, 32'h1);
    chk("run resp", 32'h0, 32'(r));
  endtask
  task automatic t_irq;
    int n, ta, t;
    n = 0;
    @(posedge aclk);
    irq <= 1'b1;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (irq_ack !== 1'b1 && n < 50);
    ta = cyc;
    @(posedge aclk);
    irq <= 1'b0;
    wait_fetch(16'h0280, t);
    chk("irq entry", 32'h6, 32'(t - ta + 3));
    ta = t;
    wait_fetch(16'h0226, t);
    chk("return length", 32'h5, 32'(t - ta));
    chk("pushed pc", 32'h0226, 32'(i_cidt_mem.mem[511]));
    chk("pushed flags", 32'h0008, 32'(i_cidt_mem.mem[510]));
    axi_rd(8'h08);
    chk("popped flags", 32'h0008, {16'h0000, d[15:0]});
  endtask
  task automatic t_wdog;
    int t;
    @(posedge aclk);
    watchdog_reset <= 1'b1;
    @(posedge aclk);
    watchdog_reset <= 1'b0;
    wait_fetch(16'h0200, t);
    chk("watchdog length", 32'h4, 32'(t - last_vec));
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, irq, watchdog_reset, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    for (int i = 0; i < 20; i++)
      i_cidt_mem.mem[256 + i] = prog[i];
    i_cidt_mem.mem[32767] = 16'h0200;
    i_cidt_mem.mem[32766] = 16'h0280;
    i_cidt_mem.mem[320] = 16'h1300;
    i_cidt_mem.mem[2330] = 16'ha5c3;
    i_cidt_mem.mem[2331] = 16'h7e11;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_timing;
    t_regs;
    t_irq;
    t_wdog;
    end_of_test;
  end
endmodule // cidt_core_tb
bind cidt_core cidt_core_asserts i_cidt_core_asserts (.*);
